/* pioc_map.svh */
`ifndef PIOC_MAP_SVH
`define PIOC_MAP_SVH
// cycle lengths in reference-clock cycles
`define PIOC_LEN_SLOW 4'h7
`define PIOC_LEN_MEDIUM 4'h6
`define PIOC_LEN_FAST 4'h5
// strobe timing inside a fixed cycle (clock index)
`define PIOC_STROBE_ON 4'h1
// strobe window closes ahead of the cycle end by this many clocks
`define PIOC_STROBE_TAIL 4'h1
// quarter-rate divider
`define PIOC_QDIV_MAX 2'h3
// control-port reset value
`define PIOC_CTRL_RESET 6'h3f
// power-on reset stretch, ns
`define PIOC_POR_NS 1000
`define PIOC_CLK_NS 4
`define PIOC_POR_CYCLES ((`PIOC_POR_NS + `PIOC_CLK_NS - 1) / `PIOC_CLK_NS)
`endif

/* pioc_pkg.sv */
package pioc_pkg;
	typedef enum logic [1:0] {
		PIOC_T_SLOW = 2'b00,
		PIOC_T_MEDIUM = 2'b01,
		PIOC_T_FAST = 2'b10,
		PIOC_T_SYNC = 2'b11
	} pioc_type_t;
	typedef enum logic [1:0] {
		PIOC_IDLE = 2'b00,
		PIOC_WAIT = 2'b01,
		PIOC_RUN = 2'b10,
		PIOC_DONE = 2'b11
	} pioc_state_t;
endpackage

/* pioc_reset_gen.sv */
`timescale 1ns/10ps
`include "pioc_map.svh"
module pioc_reset_gen
	import pioc_pkg::*;
#(
	parameter int POR_CYCLES = `PIOC_POR_CYCLES
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic porIn_n,
	input wire logic resetIn_n,
	output logic resetOut,
	output logic resetOe_n,
	output logic porEvent
);
	logic [15:0] stretchQ;
	logic porSeenQ;
	// stretch keeps peripherals held until their clock is steady
	always_ff @(posedge clock) begin
		if (!porIn_n) begin
			stretchQ <= 16'(POR_CYCLES);
		end else if (!rst_n) begin
			// system reset clears a stale count, pin never left unknown
			stretchQ <= 16'h0000;
		end else if (stretchQ != 16'h0000) begin
			stretchQ <= stretchQ - 16'h0001;
		end
	end
	// reset pin is open-drain: drive low only, enable active low
	assign resetOut = 1'b0;
	assign resetOe_n = !(!porIn_n || stretchQ != 16'h0000);
	// one pulse per power-on assertion
	always_ff @(posedge clock) begin
		porSeenQ <= !porIn_n;
	end
	assign porEvent = !porIn_n && !porSeenQ;
	stretch_held_a: assert property (@(posedge clock)
		!porIn_n |=> !resetOe_n) else $error("reset pin not driven");
endmodule

/* pioc_cycle_ctrl.sv */
`timescale 1ns/10ps
`include "pioc_map.svh"
// Functional notes
// - type code selects 7, 6 or 5 clocks
// - synchronous type waits for quarter phase
// - write latch low whole cycle
// - read latch taken as read strobe rises
// - grant and latch are open-drain
// - buffer enables always driven
// - grant never depends on request
// - idle grant from bank and chip select
// - state machine owns grant during peripheral cycle
// - either reset pin resets device
// - power-on drives reset pin low minimum
// - power-on sets latched interrupt flag
// - reset sets control pins high
// - reset returns machine to idle
// - peripheral select spans cycle
// - synchronous strobe follows quarter clock
module pioc_cycle_ctrl
	import pioc_pkg::*;
#(
	parameter int POR_CYCLES = `PIOC_POR_CYCLES,
	parameter logic [2:0] PERIPH_BANK = 3'h5
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic porIn_n,
	input wire logic resetIn_n,
	output logic resetOut,
	output logic resetOe_n,
	input wire logic io_request_n,
	input wire logic [1:0] cycle_type_select,
	input wire logic [2:0] bank_select,
	input wire logic chipSelect,
	input wire logic [2:0] periphAddr,
	input wire logic readNotWrite,
	input wire logic porFlagClear,
	output logic porFlag,
	output logic [5:0] control_port_pins,
	output logic quarterClock,
	output logic [6:0] peripheral_select_n,
	output logic read_strobe_n,
	output logic writeStrobe_n,
	output logic read_buffer_enable_n,
	output logic write_buffer_enable_n,
	output logic io_grant_nOut,
	output logic io_grant_nOe_n,
	output logic bus_latch_nOut,
	output logic bus_latch_nOe_n
);
	pioc_state_t stateQ;
	logic [3:0] countQ;
	logic [3:0] lengthQ;
	logic readQ;
	logic syncQ;
	logic [1:0] qdivQ;
	logic busLatchQ;
	logic devReset;
	logic porEvent;
	logic periphHit;
	logic start;
	logic qPhaseOk;
	logic strobeOn;

	// length lookup used at cycle start
	function automatic logic [3:0] cycleLength(input logic [1:0] code);
		unique case (pioc_type_t'(code))
			PIOC_T_SLOW: cycleLength = `PIOC_LEN_SLOW;
			PIOC_T_MEDIUM: cycleLength = `PIOC_LEN_MEDIUM;
			PIOC_T_FAST: cycleLength = `PIOC_LEN_FAST;
			PIOC_T_SYNC: cycleLength = `PIOC_LEN_FAST;
		endcase
	endfunction

	// both pins drive the internal reset; pins are synchronous inputs
	assign devReset = !rst_n || !porIn_n || !resetIn_n;

	pioc_reset_gen #(
		.POR_CYCLES(POR_CYCLES)
	) uResetGen (
		.clock(clock),
		.rst_n(rst_n),
		.porIn_n(porIn_n),
		.resetIn_n(resetIn_n),
		.resetOut(resetOut),
		.resetOe_n(resetOe_n),
		.porEvent(porEvent)
	);

	// latched power-on flag; set wins over a same-cycle clear
	always_ff @(posedge clock) begin
		if (porEvent) begin
			porFlag <= 1'b1;
		end else if (porFlagClear) begin
			porFlag <= 1'b0;
		end
	end

	// control port forced high on any reset
	always_ff @(posedge clock) begin
		if (devReset) begin
			control_port_pins <= `PIOC_CTRL_RESET;
		end
	end

	// quarter-rate clock as divider; square wave, high half period
	always_ff @(posedge clock) begin
		if (devReset) begin
			qdivQ <= 2'h0;
		end else begin
			qdivQ <= qdivQ + 2'h1;
		end
	end
	always_ff @(posedge clock) begin
		if (devReset) begin
			quarterClock <= 1'b0;
		end else begin
			quarterClock <= (qdivQ + 2'h1) >= 2'h2;
		end
	end
	// optimal start: first run edge is where the quarter clock rises,
	// so the registered strobe lines up with its high half
	assign qPhaseOk = qdivQ == 2'h0;

	assign periphHit = chipSelect && bank_select == PERIPH_BANK;
	assign start = stateQ == PIOC_IDLE && !io_request_n && periphHit;

	// cycle state machine
	always_ff @(posedge clock) begin
		if (devReset) begin
			stateQ <= PIOC_IDLE;
			countQ <= 4'h0;
		end else begin
			unique case (stateQ)
				PIOC_IDLE: begin
					countQ <= 4'h0;
					if (start) begin
						if (cycle_type_select == PIOC_T_SYNC && !qPhaseOk) begin
							stateQ <= PIOC_WAIT;
						end else begin
							stateQ <= PIOC_RUN;
						end
					end
				end
				PIOC_WAIT: begin
					// adds 0..3 sync clocks
					if (qPhaseOk) begin
						stateQ <= PIOC_RUN;
					end
				end
				PIOC_RUN: begin
					countQ <= countQ + 4'h1;
					if (countQ + 4'h1 == lengthQ - 4'h1) begin
						stateQ <= PIOC_DONE;
					end
				end
				PIOC_DONE: begin
					stateQ <= PIOC_IDLE;
					countQ <= 4'h0;
				end
			endcase
		end
	end

	// cycle attributes captured at start
	always_ff @(posedge clock) begin
		if (devReset) begin
			lengthQ <= `PIOC_LEN_FAST;
			readQ <= 1'b1;
			syncQ <= 1'b0;
			peripheral_select_n <= 7'h7f;
		end else if (start) begin
			lengthQ <= cycleLength(cycle_type_select);
			readQ <= readNotWrite;
			syncQ <= cycle_type_select == PIOC_T_SYNC;
			peripheral_select_n <= ~(7'h01 << periphAddr);
		end else if (stateQ == PIOC_DONE) begin
			peripheral_select_n <= 7'h7f;
		end
	end

	// strobe window: fixed types share one, sync follows quarter clock
	always_comb begin
		strobeOn = 1'b0;
		if (stateQ == PIOC_RUN) begin
			if (syncQ) begin
				// same term as the quarter clock register, so no skew
				strobeOn = (qdivQ + 2'h1) >= 2'h2;
			end else begin
				strobeOn = countQ + 4'h1 >= `PIOC_STROBE_ON &&
					countQ + 4'h1 < lengthQ - `PIOC_STROBE_TAIL - 4'h1;
			end
		end
	end

	// strobes registered so the pins never glitch
	always_ff @(posedge clock) begin
		if (devReset) begin
			read_strobe_n <= 1'b1;
			writeStrobe_n <= 1'b1;
		end else begin
			read_strobe_n <= !(strobeOn && readQ);
			writeStrobe_n <= !(strobeOn && !readQ);
		end
	end

	// bus latch: whole cycle on write, taken with strobe rise on read
	always_ff @(posedge clock) begin
		if (devReset || stateQ == PIOC_DONE) begin
			busLatchQ <= 1'b0;
		end else if (start && !readNotWrite) begin
			busLatchQ <= 1'b1;
		end else if (readQ && stateQ == PIOC_RUN && !read_strobe_n &&
				!strobeOn) begin
			busLatchQ <= 1'b1;
		end
	end
	// open-drain: only ever pull low
	assign bus_latch_nOut = 1'b0;
	assign bus_latch_nOe_n = !busLatchQ;

	// grant: decode when idle, machine-owned in a peripheral cycle;
	// request is never in this path so internal accesses stay 2 clocks
	always_comb begin
		logic pull;
		pull = 1'b0;
		if (stateQ == PIOC_IDLE) begin
			pull = chipSelect && bank_select != PERIPH_BANK;
		end else begin
			pull = stateQ == PIOC_DONE;
		end
		io_grant_nOut = 1'b0;
		io_grant_nOe_n = !pull;
	end

	// buffer enables driven whether or not this device is selected
	assign read_buffer_enable_n = !readNotWrite;
	assign write_buffer_enable_n = readNotWrite;

	sequence startSeq;
		start && !readNotWrite;
	endsequence
	write_latch_a: assert property (@(posedge clock) disable iff (devReset)
		startSeq |=> !bus_latch_nOe_n) else $error("latch not taken");
	grant_held_a: assert property (@(posedge clock) disable iff (devReset)
		(stateQ == PIOC_RUN) |-> io_grant_nOe_n) else $error("early grant");
	slow_len_a: assert property (@(posedge clock) disable iff (devReset)
		(start && cycle_type_select == PIOC_T_SLOW) |=> (stateQ == PIOC_RUN)
		[*6] ##1 stateQ == PIOC_DONE) else $error("slow length");
	fast_len_a: assert property (@(posedge clock) disable iff (devReset)
		(start && cycle_type_select == PIOC_T_FAST) |=> (stateQ == PIOC_RUN)
		[*4] ##1 stateQ == PIOC_DONE) else $error("fast length");
	sync_wait_a: assert property (@(posedge clock) disable iff (devReset)
		(stateQ == PIOC_WAIT) |-> ##[0:3] stateQ == PIOC_RUN) else
		$error("sync wait too long");
	select_end_a: assert property (@(posedge clock) disable iff (devReset)
		stateQ == PIOC_DONE |=> peripheral_select_n == 7'h7f) else
		$error("select held");
	idle_reset_a: assert property (@(posedge clock)
		devReset |=> stateQ == PIOC_IDLE) else $error("not idle");
	ctrl_high_a: assert property (@(posedge clock)
		devReset |=> control_port_pins == 6'h3f) else $error("ctrl");
	buffer_drv_a: assert property (@(posedge clock)
		read_buffer_enable_n != write_buffer_enable_n) else
		$error("buffers");
	por_flag_a: assert property (@(posedge clock)
		porEvent |=> porFlag) else $error("por flag");

	// read strobe rising while a read runs
	sequence readEndSeq;
		readQ && stateQ == PIOC_RUN && !read_strobe_n && !strobeOn;
	endsequence

	// a synchronous cycle in its strobe phase
	sequence syncRunSeq;
		syncQ && stateQ == PIOC_RUN;
	endsequence

	// idle access to some other bank
	sequence idleDecodeSeq;
		stateQ == PIOC_IDLE && chipSelect && bank_select != PERIPH_BANK;
	endsequence

	// further checks on cycle length, latch, strobes, grant, sync wait and select
	medium_len_a: assert property (@(posedge clock) disable iff (devReset)
		(start && cycle_type_select == PIOC_T_MEDIUM) |=>
		(stateQ == PIOC_RUN) [*5] ##1 stateQ == PIOC_DONE) else
		$error("medium length");
	read_latch_a: assert property (@(posedge clock) disable iff (devReset)
		readEndSeq |=> !bus_latch_nOe_n && read_strobe_n) else
		$error("read latch late");
	sync_strobe_a: assert property (@(posedge clock) disable iff (devReset)
		syncRunSeq |=> (read_strobe_n && writeStrobe_n) == !quarterClock)
		else $error("sync strobe skew");
	grant_decode_a: assert property (@(posedge clock) disable iff (devReset)
		idleDecodeSeq |-> !io_grant_nOe_n) else $error("no grant");
	latch_free_a: assert property (@(posedge clock) disable iff (devReset)
		stateQ == PIOC_DONE |=> bus_latch_nOe_n) else $error("latch");
	wait_sync_a: assert property (@(posedge clock) disable iff (devReset)
		stateQ == PIOC_WAIT |-> syncQ) else $error("fixed wait");
	write_dir_a: assert property (@(posedge clock) disable iff (devReset)
		!readQ && stateQ != PIOC_IDLE |-> read_strobe_n) else
		$error("read strobe in write");
	select_start_a: assert property (@(posedge clock) disable iff (devReset)
		start && periphAddr != 3'h7 |=> peripheral_select_n != 7'h7f) else
		$error("no select");
endmodule

/* pioc_host_model.sv */
`timescale 1ns/10ps
// request side of the i/o bus, holds a request until the grant is seen
module pioc_host_model (
	input wire logic clock,
	input wire logic go,
	input wire logic rd,
	input wire logic [1:0] typ,
	input wire logic [2:0] bank,
	input wire logic grantN,
	input wire logic [6:0] selN,
	input wire logic rdN,
	input wire logic wrN,
	input wire logic latchOeN,
	output logic io_request_n,
	output logic [1:0] cycle_type_select,
	output logic [2:0] bank_select,
	output logic chipSelect,
	output logic readNotWrite,
	output logic busy,
	output int lat,
	output logic [6:0] selSeen,
	output logic [2:0] seen
);
	initial begin
		io_request_n = 1'b1;
		chipSelect = 1'b0;
		cycle_type_select = 2'h0;
		bank_select = 3'h0;
		readNotWrite = 1'b1;
		busy = 1'b0;
		lat = 0;
	end
	// one transfer; bound of 12 edges so an aborted cycle cannot hang us
	always @(posedge clock) begin
		if (go && !busy) begin
			#1;
			busy = 1'b1;
			io_request_n = 1'b0;
			chipSelect = 1'b1;
			bank_select = bank;
			cycle_type_select = typ;
			readNotWrite = rd;
			lat = 0;
			selSeen = 7'h7f;
			seen = 3'h7;
			@(posedge clock);
			while (lat < 12) begin
				@(posedge clock);
				lat++;
				selSeen &= selN;
				seen &= {rdN, wrN, latchOeN};
				if (grantN === 1'b0)
					break;
			end
			#1;
			io_request_n = 1'b1;
			chipSelect = 1'b0;
			// released qualifiers show garbage, not the last value
			bank_select = ~bank_select;
			cycle_type_select = ~cycle_type_select;
			readNotWrite = ~readNotWrite;
			busy = 1'b0;
		end
	end
endmodule

/* test_peripheral_io_cycle_controller.sv */
`timescale 1ns/10ps
module test_peripheral_io_cycle_controller;
	import pioc_pkg::*;
	localparam logic [2:0] PB = 3'h5;
	logic clock, rst_n, porIn_n, resetIn_n, go, rd, porFlagClear, busy;
	logic reqN, cs, rnw, rdN, wrN, blOut, blOe, gOut, gOe, resOut, resOe;
	logic porFlag, qclk, rbe, wbe;
	logic [1:0] typ, cts;
	logic [2:0] bank, bsel, periphAddr, seen;
	logic [5:0] ctrl;
	logic [6:0] selN, selSeen;
	int lat, errors, total_checks, cycles, lo, hi;
	logic [7:0] len [4] = '{8'h07, 8'h06, 8'h05, 8'h05};
	wire grantN = gOe | gOut;
	pioc_cycle_ctrl #(.POR_CYCLES(4), .PERIPH_BANK(PB)) dut (.clock(clock),
		.rst_n(rst_n), .porIn_n(porIn_n), .resetIn_n(resetIn_n),
		.resetOut(resOut), .resetOe_n(resOe), .io_request_n(reqN),
		.cycle_type_select(cts), .bank_select(bsel), .chipSelect(cs),
		.periphAddr(periphAddr), .readNotWrite(rnw),
		.porFlagClear(porFlagClear), .porFlag(porFlag),
		.control_port_pins(ctrl), .quarterClock(qclk),
		.peripheral_select_n(selN), .read_strobe_n(rdN),
		.writeStrobe_n(wrN), .read_buffer_enable_n(rbe),
		.write_buffer_enable_n(wbe), .io_grant_nOut(gOut),
		.io_grant_nOe_n(gOe), .bus_latch_nOut(blOut),
		.bus_latch_nOe_n(blOe));
	pioc_host_model host (.clock(clock), .go(go), .rd(rd), .typ(typ),
		.bank(bank), .grantN(grantN), .selN(selN), .rdN(rdN), .wrN(wrN),
		.latchOeN(blOe), .io_request_n(reqN), .cycle_type_select(cts),
		.bank_select(bsel), .chipSelect(cs), .readNotWrite(rnw),
		.busy(busy), .lat(lat), .selSeen(selSeen), .seen(seen));
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	task automatic finish_test;
		if (errors == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// hang guard, far above the 150 or so cycles the run needs
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			finish_test;
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic start(input logic r, input logic [1:0] t,
		input logic [2:0] b, input logic [2:0] a);
		#1;
		rd = r;
		typ = t;
		bank = b;
		periphAddr = a;
		go = 1'b1;
		@(posedge clock);
		#1;
		go = 1'b0;
		@(posedge clock);
		chk(wbe, r);
	endtask
	task automatic cyc(input logic r, input logic [1:0] t,
		input logic [2:0] b, input logic [2:0] a);
		start(r, t, b, a);
		while (busy) @(posedge clock);
	endtask
	// fixed types, both directions, distinct selects
	task automatic t_types;
		for (int i = 0; i < 6; i++) begin
			cyc(i[0], i[2:1], PB, i[2:0]);
			chk(lat[7:0], len[i[2:1]]);
			chk(selSeen, 7'h7f ^ (7'h01 << i[2:0]));
			chk(seen, i[0] ? 3'h2 : 3'h4);
		end
	endtask
	// all four phases of the quarter clock give all four waits
	task automatic t_sync;
		lo = 99;
		hi = 0;
		for (int k = 0; k < 4; k++) begin
			@(posedge qclk);
			@(posedge clock);
			repeat (k) @(posedge clock);
			cyc(1'b1, 2'h3, PB, 3'h6);
			chk(lat >= 5 && lat <= 8, 1'b1);
			chk(seen, 3'h2);
			lo = lat < lo ? lat : lo;
			hi = lat > hi ? lat : hi;
		end
		chk(8'(hi - lo), 8'h03);
	endtask
	// another bank: grant from decode alone, no peripheral cycle
	task automatic t_other;
		cyc(1'b1, 2'h0, 3'h2, 3'h0);
		chk(lat[7:0], 8'h01);
		chk(selSeen, 7'h7f);
	endtask
	// reset pin in mid-cycle forces idle outputs
	task automatic t_abort;
		start(1'b0, 2'h0, PB, 3'h2);
		repeat (2) @(posedge clock);
		#1;
		resetIn_n = 1'b0;
		@(posedge clock);
		#1;
		resetIn_n = 1'b1;
		chk(selN, 7'h7f);
		chk({rdN, wrN}, 2'h3);
		while (busy) @(posedge clock);
	endtask
	task automatic t_por;
		#1;
		porIn_n = 1'b0;
		repeat (2) @(posedge clock);
		#1;
		porIn_n = 1'b1;
		chk(resOe, 1'b0);
		chk(porFlag, 1'b1);
		chk(ctrl, 6'h3f);
		repeat (6) @(posedge clock);
		#1;
		chk(resOe, 1'b1);
		porFlagClear = 1'b1;
		@(posedge clock);
		#1;
		porFlagClear = 1'b0;
		chk(porFlag, 1'b0);
	endtask
	initial begin
		{rst_n, go, rd, porFlagClear} = 4'h0;
		{porIn_n, resetIn_n} = 2'h3;
		{typ, bank, periphAddr} = 8'h00;
		repeat (10) @(posedge clock);
		#1;
		rst_n = 1'b1;
		chk(selN, 7'h7f);
		chk(ctrl, 6'h3f);
		@(posedge clock);
		t_types;
		t_sync;
		t_other;
		t_abort;
		t_por;
		finish_test;
	end
endmodule
